// >>> hdl/supply_supervisor_watchdog.sv
// Supply supervisor with reset timer, windowed watchdog and AXI4-Lite regs.
// ---------------------------------------------------------------------------
// Overview of operation
// - Period pin at supply gives an upper watchdog bound of 1.6 s.
// - Windowed mode with period pin at supply uses a 50 ms lower bound.
// - Windowed mode with a capacitor uses upper bound divided by 32.
// - Upper bound is 72 ms per nF, 3.2 ms open, 1.6 s at supply.
// - Plain mode: any kick edge before the upper bound, else reset.
// - Windowed mode: kick spacing must lie between lower and upper bounds.
// - Windowed mode counts only falling kick edges.
// - Manual reset low asserts reset; release follows one full timeout.
// - The manual reset synchroniser reads inactive high in reset; after that it follows the pin.
// - Reset is low while the supply sits below the selected threshold.
// - Reset stays low one timeout after the supply recovers.
// - Reset timeout is 9 ms per nF, 400 us open, 200 ms at supply.
// - Margin select picks -5, -10 or -15 percent below nominal.
// - Two three-state level picks choose the nominal supply voltage.
// - Reset output only pulls low or floats, never drives high.
// - Reset is held while the device supply is in lockout.
// - Supply loss during the timeout clears and later restarts the timer.
// - Comparator changes shorter than the filter time are ignored.
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
module supply_supervisor_watchdog
    import supervisor_pkg::*;
#(
    parameter logic [TIMER_W-1:0] WD_UPPER_INT = WD_UPPER_INT_CYC,
    parameter logic [TIMER_W-1:0] WD_LOWER_INT = WD_LOWER_INT_CYC,
    parameter logic [TIMER_W-1:0] WD_UPPER_OPEN = WD_UPPER_OPEN_CYC,
    parameter logic [TIMER_W-1:0] WD_PER_PF = WD_PER_PF_CYC,
    parameter logic [TIMER_W-1:0] RST_INT = RST_INT_CYC,
    parameter logic [TIMER_W-1:0] RST_OPEN = RST_OPEN_CYC,
    parameter logic [TIMER_W-1:0] RST_PER_PF = RST_PER_PF_CYC,
    parameter logic [TIMER_W-1:0] UV_FILTER = UV_FILTER_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic watchdog_kick_input,
    input wire logic manual_reset_n,
    input wire logic supply_lockout,
    input wire logic [MV_W-1:0] monitored_supply_level,
    input wire logic [1:0] nominal_level_pick_a,
    input wire logic [1:0] nominal_level_pick_b,
    input wire logic [1:0] margin_select,
    input wire logic [1:0] watchdog_period_pin,
    input wire logic [1:0] reset_delay_pin,
    output logic reset_n_out,
    output logic reset_n_oe,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [TIMER_W-1:0] strap_time(
        input logic [1:0] code,
        input logic [CAP_W-1:0] cap,
        input logic [TIMER_W-1:0] per_pf,
        input logic [TIMER_W-1:0] open_cyc,
        input logic [TIMER_W-1:0] vcc_cyc
    );
        logic [TIMER_W-1:0] t;
        t = open_cyc;
        if (code == STRAP_VCC)
            t = vcc_cyc;
        else if (code == STRAP_GND)
            t = TIMER_W'(cap) * per_pf;
        if (t == '0)
            t = TIMER_W'(1);
        return t;
    endfunction

    function automatic logic [31:0] merge_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = data[i*8 +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = 13;
    localparam logic [PIN_W-1:0] PIN_RESET = 13'h0800;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic kick_prev;
    strap_type straps;
    logic kick_now;
    logic manual_high;
    logic lockout;

    // Manual reset resets to high so it reads inactive until the pin value is synchronised.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
            kick_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= {watchdog_kick_input, manual_reset_n, supply_lockout,
                nominal_level_pick_a, nominal_level_pick_b, margin_select,
                watchdog_period_pin, reset_delay_pin};
            pin_sync <= pin_meta;
            kick_prev <= kick_now;
        end
    end

    assign kick_now = pin_sync[12];
    assign manual_high = pin_sync[11];
    assign lockout = pin_sync[10];
    assign straps = strap_type'(pin_sync[9:0]);

    // ------------------------------------------------------------------
    // Register declarations and threshold decode
    // ------------------------------------------------------------------
    logic windowed;
    logic [CAP_W-1:0] wd_cap;
    logic [CAP_W-1:0] rst_cap;
    logic [MV_W-1:0] nominal;
    logic [7:0] margin_pct;
    logic [MV_W-1:0] threshold;
    logic [23:0] scaled;

    always_comb
    begin
        unique case ({straps.pick_a, straps.pick_b})
            {STRAP_VCC, STRAP_VCC}: nominal = NOM_12000_MV;
            {STRAP_VCC, STRAP_OPEN}: nominal = NOM_5000_MV;
            {STRAP_VCC, STRAP_GND}: nominal = NOM_3300_MV;
            {STRAP_OPEN, STRAP_VCC}: nominal = NOM_2500_MV;
            {STRAP_OPEN, STRAP_GND}: nominal = NOM_1500_MV;
            {STRAP_GND, STRAP_VCC}: nominal = NOM_1200_MV;
            {STRAP_GND, STRAP_OPEN}: nominal = NOM_1000_MV;
            {STRAP_GND, STRAP_GND}: nominal = NOM_500_MV;
            default: nominal = NOM_1800_MV;
        endcase
        unique case (straps.margin)
            STRAP_VCC: margin_pct = MARGIN_5_PCT;
            STRAP_GND: margin_pct = MARGIN_15_PCT;
            default: margin_pct = MARGIN_10_PCT;
        endcase
        scaled = 24'(nominal) * 24'(PCT_FULL - margin_pct);
        threshold = MV_W'(scaled / 24'(PCT_FULL));
    end

    // ------------------------------------------------------------------
    // Supply glitch filter
    // ------------------------------------------------------------------
    logic raw_valid;
    logic supply_valid;
    logic next_supply_valid;
    logic [TIMER_W-1:0] uv_count;

    assign raw_valid = monitored_supply_level >= threshold;

    interval_timer #(.W(TIMER_W)) uv_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(raw_valid == supply_valid),
        .count(uv_count)
    );

    always_comb
    begin
        next_supply_valid = supply_valid;
        if (raw_valid != supply_valid && uv_count >= UV_FILTER - 1'b1)
            next_supply_valid = raw_valid;
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    reset_state_type state;
    reset_state_type next_state;
    logic [TIMER_W-1:0] wd_count;
    logic [TIMER_W-1:0] wd_upper;
    logic [TIMER_W-1:0] wd_lower;
    logic wd_disabled;
    logic kick;
    logic wd_fault;

    always_comb
    begin
        wd_upper = strap_time(straps.period, wd_cap, WD_PER_PF,
            WD_UPPER_OPEN, WD_UPPER_INT);
        if (straps.period == STRAP_VCC)
            wd_lower = WD_LOWER_INT;
        else
            wd_lower = wd_upper >> LOWER_DIV_SHIFT;
        wd_disabled = straps.period == STRAP_GND && wd_cap == '0;
        if (windowed)
            kick = kick_prev && !kick_now;
        else
            kick = kick_prev ^ kick_now;
        wd_fault = state == ST_RUN && !wd_disabled &&
            (wd_count >= wd_upper || (windowed && kick &&
            wd_count < wd_lower));
    end

    interval_timer #(.W(TIMER_W)) wd_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(kick || state != ST_RUN),
        .count(wd_count)
    );

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    logic hold;
    logic [TIMER_W-1:0] rst_count;
    logic [TIMER_W-1:0] rst_time;
    logic wd_cause;
    logic next_wd_cause;
    logic next_drive;

    interval_timer #(.W(TIMER_W)) rst_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(state != ST_TIMING),
        .count(rst_count)
    );

    always_comb
    begin
        hold = !supply_valid || lockout || !manual_high;
        rst_time = strap_time(straps.delay, rst_cap, RST_PER_PF,
            RST_OPEN, RST_INT);
        next_state = state;
        unique case (state)
            ST_HOLD:
                if (!hold)
                    next_state = ST_TIMING;
            ST_TIMING:
                if (hold)
                    next_state = ST_HOLD;
                else if (rst_count >= rst_time - 1'b1)
                    next_state = ST_RUN;
            ST_RUN:
                if (hold || wd_fault)
                    next_state = ST_HOLD;
        endcase
        next_wd_cause = wd_cause;
        if (wd_fault)
            next_wd_cause = 1'b1;
        else if (hold)
            next_wd_cause = 1'b0;
        next_drive = next_state != ST_RUN;
    end

    // The pad only ever sinks current; the high level comes from outside.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_HOLD;
            supply_valid <= 1'b0;
            wd_cause <= 1'b0;
            reset_n_oe <= 1'b1;
        end
        else
        begin
            state <= next_state;
            supply_valid <= next_supply_valid;
            wd_cause <= next_wd_cause;
            reset_n_oe <= next_drive;
        end
    end

    assign reset_n_out = 1'b0;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_windowed;
    logic [CAP_W-1:0] next_wd_cap;
    logic [CAP_W-1:0] next_rst_cap;
    logic [31:0] merged;
    status_type status;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        status = '{16'h0000, straps, wd_cause, wd_disabled, manual_high,
            lockout, supply_valid, reset_n_oe};
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_windowed = windowed;
        next_wd_cap = wd_cap;
        next_rst_cap = rst_cap;
        merged = '0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr & ADDR_MASK;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (aw_addr)
                REG_CONTROL:
                begin
                    merged = merge_strb(32'(windowed), w_data, w_strb);
                    next_windowed = merged[0];
                end
                REG_WD_CAP:
                begin
                    merged = merge_strb(32'(wd_cap), w_data, w_strb);
                    next_wd_cap = merged[CAP_W-1:0];
                end
                REG_RST_CAP:
                begin
                    merged = merge_strb(32'(rst_cap), w_data, w_strb);
                    next_rst_cap = merged[CAP_W-1:0];
                end
                REG_STATUS, REG_THRESHOLD: ;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            unique case (s_axi_araddr & ADDR_MASK)
                REG_CONTROL: next_rdata = 32'(windowed);
                REG_WD_CAP: next_rdata = 32'(wd_cap);
                REG_RST_CAP: next_rdata = 32'(rst_cap);
                REG_STATUS: next_rdata = status;
                REG_THRESHOLD: next_rdata = 32'(threshold);
                default:
                begin
                    next_rdata = '0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            windowed <= 1'b0;
            wd_cap <= '0;
            rst_cap <= '0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            windowed <= next_windowed;
            wd_cap <= next_wd_cap;
            rst_cap <= next_rst_cap;
        end
    end
endmodule

// >>> hdl/supervisor_pkg.sv
// Constants, register map and types for the supply supervisor and watchdog.
package supervisor_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Cycle counts at the 100 MHz system clock.
    localparam logic [31:0] WD_UPPER_INT_CYC = 32'h09896800;
    localparam logic [31:0] WD_LOWER_INT_CYC = 32'h004c4b40;
    localparam logic [31:0] WD_UPPER_OPEN_CYC = 32'h0004e200;
    localparam logic [31:0] WD_PER_PF_CYC = 32'h00001c20;
    localparam logic [31:0] RST_INT_CYC = 32'h01312d00;
    localparam logic [31:0] RST_OPEN_CYC = 32'h00009c40;
    localparam logic [31:0] RST_PER_PF_CYC = 32'h00000384;
    localparam logic [31:0] UV_FILTER_CYC = 32'h00001f40;
    localparam int TIMER_W = 32;
    localparam int unsigned LOWER_DIV_SHIFT = 5;

    // ------------------------------------------------------------------
    // Strap decoding
    // ------------------------------------------------------------------
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_VCC = 2'h2;
    localparam int MV_W = 16;
    localparam logic [MV_W-1:0] NOM_12000_MV = 16'h2ee0;
    localparam logic [MV_W-1:0] NOM_5000_MV = 16'h1388;
    localparam logic [MV_W-1:0] NOM_3300_MV = 16'h0ce4;
    localparam logic [MV_W-1:0] NOM_2500_MV = 16'h09c4;
    localparam logic [MV_W-1:0] NOM_1800_MV = 16'h0708;
    localparam logic [MV_W-1:0] NOM_1500_MV = 16'h05dc;
    localparam logic [MV_W-1:0] NOM_1200_MV = 16'h04b0;
    localparam logic [MV_W-1:0] NOM_1000_MV = 16'h03e8;
    localparam logic [MV_W-1:0] NOM_500_MV = 16'h01f4;
    localparam logic [7:0] MARGIN_5_PCT = 8'h05;
    localparam logic [7:0] MARGIN_10_PCT = 8'h0a;
    localparam logic [7:0] MARGIN_15_PCT = 8'h0f;
    localparam logic [7:0] PCT_FULL = 8'h64;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int CAP_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h1c;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_WD_CAP = 5'h04;
    localparam logic [ADDR_W-1:0] REG_RST_CAP = 5'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] REG_THRESHOLD = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] pick_a;
        logic [1:0] pick_b;
        logic [1:0] margin;
        logic [1:0] period;
        logic [1:0] delay;
    } strap_type;

    typedef struct packed {
        logic [15:0] zero;
        strap_type straps;
        logic wd_cause;
        logic wd_disabled;
        logic manual_high;
        logic lockout;
        logic supply_valid;
        logic reset_asserted;
    } status_type;

    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_TIMING = 2'h1,
        ST_RUN = 2'h2
    } reset_state_type;

endpackage

// >>> hdl/interval_timer.sv
// Saturating up-counter used for timeouts and the glitch filter.
`timescale 1ns/1ps
module interval_timer
    import supervisor_pkg::*;
#(
    parameter int W = TIMER_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    output logic [W-1:0] count
);
    logic [W-1:0] next_count;

    // Saturation keeps a stalled timer from wrapping into a false short count.
    always_comb
    begin
        next_count = count;
        if (clear)
            next_count = '0;
        else if (count != '1)
            next_count = count + 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            count <= '0;
        else
            count <= next_count;
    end
endmodule

// >>> verification/kick_host.sv
// Host model that toggles the watchdog kick while it is out of reset.
`timescale 1ns/1ps
module kick_host
(
    input wire logic sys_clk,
    input wire logic reset_pin,
    input wire logic enable,
    input wire logic [15:0] half,
    output logic kick = 1'b0
);
    logic [15:0] count = 16'h0000;
    // Kick is parked low in reset, so the first edge after release rises.
    always_ff @(posedge sys_clk)
    begin
        if (!enable || !reset_pin)
        begin
            kick <= 1'b0;
            count <= 16'h0000;
        end
        else if (count >= half - 16'h0001)
        begin
            kick <= !kick;
            count <= 16'h0000;
        end
        else
            count <= count + 16'h0001;
    end
endmodule

// >>> verification/supervisor_checker.sv
// Assertions on the reset pin and the register bus of the supervisor.
`timescale 1ns/1ps
module supervisor_checker
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic manual_reset_n,
    input wire logic supply_lockout,
    input wire logic reset_n_out,
    input wire logic reset_n_oe,
    input wire logic s_axi_awready,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    pin_low_only_a: assert property (!reset_n_out)
        else $error("pin high");
    manual_hold_a: assert property (
        $fell(manual_reset_n) |-> ##[1:6] reset_n_oe)
        else $error("manual no reset");
    manual_wait_a: assert property (
        $rose(manual_reset_n) |=> reset_n_oe [*8])
        else $error("manual early");
    lockout_hold_a: assert property (
        $rose(supply_lockout) |-> ##[1:6] reset_n_oe)
        else $error("lockout no reset");
    lockout_wait_a: assert property (
        $fell(supply_lockout) |-> ##1 reset_n_oe [*8])
        else $error("lockout early");
    write_done_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held");
    read_done_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    cover property ($fell(reset_n_oe));
    cover property ($rose(reset_n_oe));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

// >>> verification/supply_supervisor_watchdog_tb_top.sv
// Self-checking bench for the supply supervisor and watchdog.
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb_top
    import supervisor_pkg::*;
();
    logic sys_clk = 1'b0, rst = 1'b1, kick_en = 1'b0, kick, reset_pin;
    logic manual_reset_n = 1'b1, supply_lockout = 1'b0;
    logic [MV_W-1:0] level = 16'h0000;
    logic [15:0] half = 16'h0064;
    strap_type straps = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h1};
    logic reset_n_out, reset_n_oe, s_axi_awready, s_axi_wready;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0, total_checks = 0;
    // The pull-up gives the high level whenever nobody pulls down.
    assign reset_pin = reset_n_oe ? reset_n_out : 1'b1;
    supply_supervisor_watchdog #(.WD_PER_PF(32'ha), .RST_OPEN(32'h32),
        .UV_FILTER(32'h8))
    u_supply_supervisor_watchdog (.*, .watchdog_kick_input(kick),
        .monitored_supply_level(level),
        .nominal_level_pick_a(straps.pick_a),
        .nominal_level_pick_b(straps.pick_b),
        .margin_select(straps.margin), .watchdog_period_pin(straps.period),
        .reset_delay_pin(straps.delay));
    kick_host u_kick_host (.sys_clk, .reset_pin, .enable(kick_en),
        .half, .kick);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Counts edges until the pull-down enable shows v, at most lim.
    task automatic watch(input logic v, input int lim, output int n);
        n = 0;
        while (reset_n_oe !== v && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, d);
        check(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] thr[3] = '{32'h109a, 32'h1194, 32'h128e};
        rd_chk(REG_CONTROL, 32'h0, RESP_OKAY);
        rd_chk(REG_WD_CAP, 32'h0, RESP_OKAY);
        rd_chk(REG_STATUS, 32'h9859, RESP_OKAY);
        for (int i = 0; i < 3; i++)
        begin
            straps.margin <= i[1:0];
            repeat (3) @(posedge sys_clk);
            rd_chk(REG_THRESHOLD, thr[i], RESP_OKAY);
        end
        wr(REG_THRESHOLD, 32'h0, RESP_OKAY);
        rd_chk(REG_THRESHOLD, 32'h128e, RESP_OKAY);
        rd_chk(5'h14, 32'h0, RESP_SLVERR);
        $display("register test done");
    endtask
    task automatic t_supply();
        int n;
        level <= 16'h1388;
        watch(1'b0, 200, n);
        check(n >= 55 && n <= 70, 1);
        level <= 16'h1000;
        repeat (4) @(posedge sys_clk);
        level <= 16'h1388;
        watch(1'b1, 100, n);
        check(n, 100);
        level <= 16'h128d;
        watch(1'b1, 40, n);
        check(n < 40, 1);
        level <= 16'h128e;
        repeat (40) @(posedge sys_clk);
        level <= 16'h0000;
        repeat (20) @(posedge sys_clk);
        level <= 16'h128e;
        watch(1'b0, 200, n);
        check(n >= 55 && n <= 70, 1);
        $display("supply test done");
    endtask
    task automatic t_pins();
        int n;
        for (int i = 0; i < 2; i++)
        begin
            manual_reset_n <= i[0];
            supply_lockout <= i[0];
            watch(1'b1, 20, n);
            check(n < 20, 1);
            repeat (10) @(posedge sys_clk);
            manual_reset_n <= 1'b1;
            supply_lockout <= 1'b0;
            watch(1'b0, 200, n);
            check(n >= 50 && n <= 60, 1);
        end
        $display("pin test done");
    endtask
    task automatic t_disable();
        int n;
        watch(1'b1, 1000, n);
        check(n, 1000);
        kick_en <= 1'b1;
        repeat (120) @(posedge sys_clk);
        wr(REG_WD_CAP, 32'h28, RESP_OKAY);
        rd_chk(REG_WD_CAP, 32'h28, RESP_OKAY);
        $display("disable test done");
    endtask
    task automatic t_plain();
        int n;
        watch(1'b1, 2000, n);
        check(n, 2000);
        half <= 16'h012c;
        watch(1'b1, 1500, n);
        check(n, 1500);
        kick_en <= 1'b0;
        watch(1'b1, 800, n);
        check(n < 800, 1);
        watch(1'b0, 200, n);
        watch(1'b1, 600, n);
        check(n >= 395 && n <= 410, 1);
        kick_en <= 1'b1;
        half <= 16'h0064;
        watch(1'b0, 200, n);
        $display("plain test done");
    endtask
    task automatic t_window();
        int n;
        wr(REG_CONTROL, 32'h1, RESP_OKAY);
        watch(1'b1, 1500, n);
        check(n, 1500);
        half <= 16'h012c;
        watch(1'b1, 1500, n);
        check(n < 1500, 1);
        half <= 16'h0008;
        watch(1'b0, 200, n);
        watch(1'b1, 600, n);
        check(n, 600);
        half <= 16'h0005;
        watch(1'b1, 100, n);
        check(n < 100, 1);
        half <= 16'h0064;
        wr(REG_CONTROL, 32'h0, RESP_OKAY);
        $display("window test done");
    endtask
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #900000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_supply();
        t_pins();
        t_disable();
        t_plain();
        t_window();
        end_sim();
    end
endmodule
bind supply_supervisor_watchdog supervisor_checker u_supervisor_checker
    (.*);
